// File: gfttr_pkg.sv
// Constants, register map and types of the gated frequency trigger
package gfttr_pkg;

  // Timing
  localparam int CLK_HZ       = 50_000_000;
  localparam int GATE_UNIT_MS = 10;
  localparam int TICK_CYC     = GATE_UNIT_MS * (CLK_HZ / 1000);

  // Widths and limits
  localparam int          CNT_W   = 20;
  localparam logic [13:0] LVL_MAX = 14'h270f;

  // Register byte offsets
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_SET    = 5'h04;
  localparam logic [4:0] OFS_CLR    = 5'h08;
  localparam logic [4:0] OFS_GATE   = 5'h0c;
  localparam logic [4:0] OFS_BLK    = 5'h10;
  localparam logic [4:0] OFS_STATUS = 5'h14;
  localparam logic [4:0] OFS_RATE   = 5'h18;
  localparam logic [4:0] OFS_RUN    = 5'h1c;

  // Field positions
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_SRC_BIT = 1;
  localparam int STAT_OUT_BIT = 0;
  localparam int STAT_RUN_BIT = 1;

  // Reset values
  localparam logic        CTRL_EN_RST  = 1'b0;
  localparam logic        CTRL_SRC_RST = 1'b0;
  localparam logic [7:0]  BLK_RST      = 8'h00;
  localparam logic [13:0] SET_RST      = 14'h0000;
  localparam logic [13:0] CLR_RST      = 14'h0000;
  localparam logic [13:0] GATE_RST     = 14'h0064;

  typedef struct packed {
    logic        en;
    logic        src_ext;
    logic [7:0]  blk;
    logic [13:0] set_lvl;
    logic [13:0] clr_lvl;
    logic [13:0] gate;
  } gfttr_cfg_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ANS  = 2'b01
  } gfttr_bus_t;

endpackage : gfttr_pkg

// File: gfttr_pulse_src.sv
// Pulse source model standing in for a fast digital input
module gfttr_pulse_src (
  input  wire logic clock,
  output logic      pulse
);
  timeunit 1ns;
  timeprecision 1ps;

  initial pulse = 1'b0;

  // High two cycles, low two: only the rising edge may count
  task automatic fire(input int n);
    repeat (n)
    begin
      @(posedge clock) pulse <= 1'b1;
      repeat (2) @(posedge clock);
      pulse <= 1'b0;
      @(posedge clock);
    end
  endtask : fire
endmodule : gfttr_pulse_src

// File: gfttr_top.sv
// Gated frequency threshold trigger with Avalon-MM register slave
//
// Functional notes
// - Count only rising edges of pulse input
// - Count up to 5 kHz without loss
// - Set and clear levels range 0 to 9999
// - Gate interval 00:00 to 99:99 seconds
// - Accumulate edges across each gate interval
// - Measured rate equals count per gate
// - Evaluate thresholds only at gate boundary
// - Hysteresis when set level not below clear
// - Window detect when set below clear
// - Gate always counted in 10 ms timebase
// - Gate may come from another block
module gfttr_top
  import gfttr_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        pulse_in,
  input  wire logic [15:0] blk_value,
  output logic      [7:0]  blk_sel,
  output logic             trig_out
);

  //////////////////////////////////////////////////////////////////////
  // Declarations

  gfttr_cfg_t       cfg_r;
  gfttr_bus_t       bus_r;
  logic [31:0]      rdata_r;
  logic             wait_r;
  logic             pulse_prev_r;
  logic [31:0]      tick_cnt_r;
  logic [13:0]      gate_cnt_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] rate_r;
  logic             out_r;
  logic             rise;
  logic             tick;
  logic             gate_end;
  logic             evt;
  logic [13:0]      gate_len;
  logic [CNT_W-1:0] meas_nxt;
  logic             out_nxt;
  logic             wr_go;

  //////////////////////////////////////////////////////////////////////
  // Functions

  // Out of range settings saturate rather than wrap
  function automatic logic [13:0] clamp_lvl(input logic [15:0] v);
    if (v > {2'b00, LVL_MAX})
    begin
      return LVL_MAX;
    end
    return v[13:0];
  endfunction : clamp_lvl

  function automatic logic [CNT_W-1:0] sat_inc(
    input logic [CNT_W-1:0] v,
    input logic             inc
  );
    if (inc && (v != {CNT_W{1'b1}}))
    begin
      return v + {{(CNT_W-1){1'b0}}, 1'b1};
    end
    return v;
  endfunction : sat_inc

  function automatic logic decide(
    input logic [CNT_W-1:0] f,
    input logic [13:0]      on_l,
    input logic [13:0]      off_l,
    input logic             prev
  );
    logic [CNT_W-1:0] on_w;
    logic [CNT_W-1:0] off_w;
    on_w  = CNT_W'(on_l);
    off_w = CNT_W'(off_l);
    if (on_l >= off_l)
    begin
      if (f > on_w)
      begin
        return 1'b1;
      end
      if (f <= off_w)
      begin
        return 1'b0;
      end
      return prev;
    end
    return (f >= on_w) && (f < off_w);
  endfunction : decide

  //////////////////////////////////////////////////////////////////////
  // Gate timing

  assign rise     = pulse_in & ~pulse_prev_r;
  // Gate of zero is stretched to one unit so boundaries never stop
  assign gate_len = cfg_r.src_ext ? clamp_lvl(blk_value) : cfg_r.gate;
  assign tick     = (tick_cnt_r == 32'(TICK_CYCLES - 1));
  assign gate_end = tick && ((gate_cnt_r + 14'h0001) >= gate_len);
  assign evt      = ce && cfg_r.en && gate_end;
  assign meas_nxt = sat_inc(cnt_r, rise);
  assign out_nxt  = decide(meas_nxt, cfg_r.set_lvl, cfg_r.clr_lvl, out_r);

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      pulse_prev_r <= 1'b0;
    end
    else if (ce)
    begin
      pulse_prev_r <= pulse_in;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      tick_cnt_r <= 32'h0000_0000;
      gate_cnt_r <= 14'h0000;
    end
    else if (ce)
    begin
      if (!cfg_r.en || tick)
      begin
        tick_cnt_r <= 32'h0000_0000;
      end
      else
      begin
        tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      end
      if (!cfg_r.en || gate_end)
      begin
        gate_cnt_r <= 14'h0000;
      end
      else if (tick)
      begin
        gate_cnt_r <= gate_cnt_r + 14'h0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Pulse count, latch and threshold decision

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      cnt_r <= '0;
    end
    else if (ce)
    begin
      if (!cfg_r.en || gate_end)
      begin
        cnt_r <= '0;
      end
      else
      begin
        cnt_r <= meas_nxt;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rate_r <= '0;
      out_r  <= 1'b0;
    end
    else if (evt)
    begin
      rate_r <= meas_nxt;
      out_r  <= out_nxt;
    end
  end

  assign trig_out = out_r;
  assign blk_sel  = cfg_r.blk;

  //////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then the answer edge

  assign wr_go = (bus_r == BUS_ANS) && avs_write;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      bus_r  <= BUS_IDLE;
      wait_r <= 1'b1;
    end
    else if (ce)
    begin
      case (bus_r)
        BUS_IDLE:
        begin
          if (avs_read || avs_write)
          begin
            bus_r  <= BUS_ANS;
            wait_r <= 1'b0;
          end
        end
        BUS_ANS:
        begin
          bus_r  <= BUS_IDLE;
          wait_r <= 1'b1;
        end
        default:
        begin
          bus_r  <= BUS_IDLE;
          wait_r <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rdata_r <= 32'h0000_0000;
    end
    else if (ce && (bus_r == BUS_IDLE) && avs_read)
    begin
      case ({avs_address[4:2], 2'b00})
        OFS_CTRL:   rdata_r <= {30'h0, cfg_r.src_ext, cfg_r.en};
        OFS_SET:    rdata_r <= {18'h0, cfg_r.set_lvl};
        OFS_CLR:    rdata_r <= {18'h0, cfg_r.clr_lvl};
        OFS_GATE:   rdata_r <= {18'h0, cfg_r.gate};
        OFS_BLK:    rdata_r <= {24'h0, cfg_r.blk};
        OFS_STATUS: rdata_r <= {30'h0, cfg_r.en, out_r};
        OFS_RATE:   rdata_r <= {12'h0, rate_r};
        OFS_RUN:    rdata_r <= {12'h0, cnt_r};
        default:    rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // Levels are narrow: data comes from the low two byte lanes, but only avs_byteenable[0] gates the write
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      cfg_r.en      <= CTRL_EN_RST;
      cfg_r.src_ext <= CTRL_SRC_RST;
      cfg_r.blk     <= BLK_RST;
      cfg_r.set_lvl <= SET_RST;
      cfg_r.clr_lvl <= CLR_RST;
      cfg_r.gate    <= GATE_RST;
    end
    else if (ce && wr_go && avs_byteenable[0])
    begin
      case ({avs_address[4:2], 2'b00})
        OFS_CTRL:
        begin
          cfg_r.en      <= avs_writedata[CTRL_EN_BIT];
          cfg_r.src_ext <= avs_writedata[CTRL_SRC_BIT];
        end
        OFS_SET:  cfg_r.set_lvl <= clamp_lvl(avs_writedata[15:0]);
        OFS_CLR:  cfg_r.clr_lvl <= clamp_lvl(avs_writedata[15:0]);
        OFS_GATE: cfg_r.gate    <= clamp_lvl(avs_writedata[15:0]);
        OFS_BLK:  cfg_r.blk     <= avs_writedata[7:0];
        default:  cfg_r.blk     <= cfg_r.blk;
      endcase
    end
  end

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;

  //////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_rise_mid;
    ce && cfg_r.en && rise && !gate_end && (cnt_r != {CNT_W{1'b1}});
  endsequence

  sequence s_gate_end;
    evt;
  endsequence

  sequence s_hyst;
    evt && (cfg_r.set_lvl >= cfg_r.clr_lvl);
  endsequence

  rise_count_a: assert property (s_rise_mid |=> cnt_r == $past(cnt_r) + 1'b1)
    else $error("rising edge not counted");

  // Disable clears the count, so only an enabled idle cycle must hold it
  fall_ignore_a: assert property (ce && cfg_r.en && !rise && !gate_end
    |=> cnt_r == $past(cnt_r))
    else $error("count moved without a rising edge");

  rate_latch_a: assert property (s_gate_end |=> rate_r == $past(meas_nxt))
    else $error("rate not latched at gate end");

  count_clear_a: assert property (s_gate_end |=> cnt_r == '0)
    else $error("counter not cleared at gate end");

  out_hold_a: assert property (!evt |=> $stable(trig_out) && $stable(rate_r))
    else $error("output changed between gate ends");

  hyst_set_a: assert property (
    (s_hyst and (meas_nxt > CNT_W'(cfg_r.set_lvl))) |=> trig_out)
    else $error("hysteresis set missed");

  hyst_clear_a: assert property (
    (s_hyst and (meas_nxt <= CNT_W'(cfg_r.clr_lvl))) |=> !trig_out)
    else $error("hysteresis clear missed");

  window_a: assert property (evt && (cfg_r.set_lvl < cfg_r.clr_lvl)
    |=> trig_out == ($past(meas_nxt) >= CNT_W'($past(cfg_r.set_lvl))
                 && $past(meas_nxt) < CNT_W'($past(cfg_r.clr_lvl))))
    else $error("window decision wrong");

  level_range_a: assert property (cfg_r.set_lvl <= LVL_MAX
    && cfg_r.clr_lvl <= LVL_MAX)
    else $error("level beyond range");

  gate_range_a: assert property (cfg_r.gate <= LVL_MAX && gate_len <= LVL_MAX)
    else $error("gate beyond range");

  tick_period_a: assert property (ce && tick |=> tick_cnt_r == 32'h0000_0000)
    else $error("tick counter did not wrap");

  ext_gate_a: assert property (cfg_r.src_ext && blk_value <= 16'(LVL_MAX)
    |-> gate_len == blk_value[13:0])
    else $error("external gate not used");

  bus_answer_a: assert property (ce && wait_r && (avs_read || avs_write)
    |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer timing wrong");

endmodule : gfttr_top

// File: test_gfttr_top.sv
// Self-checking bench of the gated frequency trigger
module test_gfttr_top
  import gfttr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock;
  logic        sys_rst;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        pulse_in;
  logic [15:0] blk_value;
  logic [7:0]  blk_sel;
  logic        trig_out;
  logic [31:0] rdat;
  logic        prev;
  int          fail_count;
  int          n_compared;

  // Short tick keeps each gate unit at four cycles
  gfttr_top #(.TICK_CYCLES(4)) dut (
    .clock          (clock),
    .sys_rst        (sys_rst),
    .ce             (1'b1),
    .avs_address    (avs_address),
    .avs_read       (avs_read),
    .avs_write      (avs_write),
    .avs_writedata  (avs_writedata),
    .avs_byteenable (4'hf),
    .avs_readdata   (avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .pulse_in       (pulse_in),
    .blk_value      (blk_value),
    .blk_sel        (blk_sel),
    .trig_out       (trig_out)
  );

  gfttr_pulse_src src (
    .clock(clock),
    .pulse(pulse_in)
  );

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("Compared %0d, errors %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= d;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0)
        break;
    end
    rdat = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (i == 20)
    begin
      fail_count++;
      wrap_up();
    end
  endtask : bus

  // Fresh gate each time; disabling holds trig_out, so hysteresis carries over
  task automatic measure(input logic [31:0] ctl, input int n, input logic exp_trig);
    int i;
    bus(1'b1, OFS_CTRL, 32'h0);
    bus(1'b1, OFS_CTRL, ctl);
    src.fire(n);
    chk({31'h0, prev}, {31'h0, trig_out});
    for (i = 0; i < 400; i++)
    begin
      bus(1'b0, OFS_RATE, 32'h0);
      if (rdat === n)
        break;
    end
    chk(n, rdat);
    chk({31'h0, exp_trig}, {31'h0, trig_out});
    prev = exp_trig;
  endtask : measure

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    bus(1'b0, OFS_GATE, 32'h0);
    chk(32'h64, rdat);
    bus(1'b0, OFS_CTRL, 32'h0);
    chk(32'h0, rdat);
    chk(32'h0, {24'h0, blk_sel});
    chk(32'h0, {31'h0, trig_out});
  endtask : t_reset

  task automatic t_levels;
    bus(1'b1, OFS_SET, 32'hffff);
    bus(1'b0, OFS_SET, 32'h0);
    chk(32'h270f, rdat);
    bus(1'b1, OFS_BLK, 32'h7);
    // The write lands on the answer edge; look once it has settled
    @(negedge clock);
    chk(32'h7, {24'h0, blk_sel});
    bus(1'b1, OFS_GATE, 32'h32);
  endtask : t_levels

  task automatic t_hyst;
    bus(1'b1, OFS_SET, 32'h5);
    bus(1'b1, OFS_CLR, 32'h2);
    measure(32'h1, 6, 1'b1);
    measure(32'h1, 3, 1'b1);
    measure(32'h1, 2, 1'b0);
  endtask : t_hyst

  task automatic t_window;
    bus(1'b1, OFS_SET, 32'h3);
    bus(1'b1, OFS_CLR, 32'h6);
    measure(32'h1, 3, 1'b1);
    measure(32'h1, 6, 1'b0);
    measure(32'h1, 2, 1'b0);
  endtask : t_window

  // Own gate far too long to answer in time: only the external gate can
  task automatic t_ext;
    bus(1'b1, OFS_GATE, 32'h7d0);
    blk_value <= 16'h0032;
    measure(32'h3, 4, 1'b1);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(32'h3, rdat);
  endtask : t_ext

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_rst       = 1'b1;
    avs_address   = 5'h00;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0;
    blk_value     = 16'h0000;
    prev          = 1'b0;
    fail_count    = 0;
    n_compared    = 0;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_levels();
    t_hyst();
    t_window();
    t_ext();
    wrap_up();
  end

  initial
  begin
    repeat (100000) @(posedge clock);
    fail_count++;
    wrap_up();
  end
endmodule : test_gfttr_top
